// ### core/pot_consts.svh
// constants of the path overhead termination block
`ifndef POT_CONSTS_SVH
`define POT_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define POT_CLK_MHZ 50
`define POT_SEC_US 1000000
`define POT_FRAME_US 125
`define POT_RUN_FRAMES 5

// ----------------------------------------
// overhead positions within a frame
// ----------------------------------------
`define POT_POS_SYNC_HI 12'h000
`define POT_POS_SYNC_LO 12'h001
`define POT_POS_TRACE 12'h002
`define POT_POS_PARITY 12'h003
`define POT_POS_STATUS 12'h004
`define POT_POS_COMMS 12'h005
`define POT_PAYLOAD_BYTES 2160
`define POT_SYNC_WORD 16'haa55

// ----------------------------------------
// status octet fields (bit 1 is the msb)
// ----------------------------------------
`define POT_MA_FAULT 7
`define POT_MA_ERROR 6
`define POT_MA_LABEL_HI 5
`define POT_MA_LABEL_LO 3

// ----------------------------------------
// register offsets
// ----------------------------------------
`define POT_REG_CTRL 8'h00
`define POT_REG_DEGRADE 8'h04
`define POT_REG_STATUS 8'h08
`define POT_REG_PERF 8'h0c
`define POT_REG_SENT 8'h10
`define POT_REG_EXPECT 8'h20
`define POT_REG_ACCEPT 8'h30

// ----------------------------------------
// control and status bits, reset values
// ----------------------------------------
`define POT_CTRL_TRACE_DIS 0
`define POT_CTRL_SSF_REP 1
`define POT_CTRL_FF_REP 2
`define POT_CTRL_GATE 3
`define POT_DEG_LIMIT_RST 16'h0000
`define POT_DEG_WIN_RST 4'h2
`define POT_ST_UNEQ 0
`define POT_ST_TIM 1
`define POT_ST_DEG 2
`define POT_ST_FF 3
`define POT_ST_C_UNEQ 4
`define POT_ST_C_TIM 5
`define POT_ST_C_DEG 6
`define POT_ST_C_FF 7
`define POT_ST_C_SSF 8
`define POT_ST_NEAR_SEC 9
`define POT_ST_FAR_SEC 10
`define POT_ST_FILL 11
`define POT_ST_TF 12
`define POT_ST_TD 13

`endif

// ### core/pot_pkg.sv
// types of the path overhead termination block
package pot_pkg;

	typedef struct packed
	{
		logic trace_check_disable;
		logic server_fail_report_enable;
		logic far_fault_report_enable;
		logic fault_report_gate;
		logic [15:0] degrade_limit;
		logic [3:0] degrade_window_count;
		logic [15:0][7:0] sent_trace_id;
		logic [15:0][7:0] expected_trace_id;
	} pot_cfg_t;

	typedef struct packed
	{
		logic [11:0] pos;
		logic [3:0] tidx;
		logic [7:0] par;
		logic [7:0] last_par;
		logic [7:0] data;
		logic fs;
	} pot_src_t;

	typedef struct packed
	{
		logic [11:0] pos;
		logic [3:0] tidx;
		logic [7:0] par;
		logic [7:0] last_par;
		logic [15:0][7:0] accepted_trace_id;
		logic [2:0] label_run;
		logic no_payload_defect;
		logic [2:0] fault_run;
		logic far_fault_defect;
		logic trace_mismatch_defect;
		logic error_rate_defect;
		logic [3:0] deg_run;
		logic frame_err;
		logic near_errored_block;
		logic far_errored_block;
		logic [7:0] data;
		logic fs;
		logic tf;
		logic td;
		logic [25:0] sec_cnt;
		logic [15:0] near_acc;
		logic [15:0] far_acc;
		logic near_acc_ds;
		logic far_acc_ds;
		logic [15:0] near_block_count;
		logic [15:0] far_block_count;
		logic near_defect_second;
		logic far_defect_second;
	} pot_snk_t;

	typedef struct packed
	{
		logic clk;
		logic ai_fs;
		logic [7:0] ai_data;
		logic rx_fs;
		logic [7:0] rx_data;
		logic ssf;
		logic eqd;
	} pot_pins_t;

endpackage

// ### core/pot_top.sv
// path overhead termination: source and sink of one trail, apb registers
//
// Summary of operation
// - octet stream in 125 us frames
// - payload and status bits pass through
// - comms channel octet passes unchanged
// - sent trace inserted byte per frame
// - status bit 1 follows far fault request
// - status bit 2 follows far error request
// - even parity of previous frame inserted
// - sync word inserted once per frame
// - sink parity mismatch marks errored block
// - sixteen byte trace recovered for software
// - only first trace mode supported
// - far defect bit 1, error bit 2
// - far error flag counts far block
// - label bits extracted for unequipped detection
// - all ones fill on unequipped or mismatch
// - trail fail, far fault, degrade actions
// - unequipped and mismatch causes gated
// - degrade cause masked by higher defects
// - far fault cause needs enable
// - server fail cause needs enable
// - per second defect flags and counts
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pot_consts.svh"

module pot_top
#(
	parameter int SEC_CYCLES = `POT_SEC_US * `POT_CLK_MHZ,
	parameter logic [15:0] SYNC_WORD = `POT_SYNC_WORD,
	parameter int RUN_FRAMES = `POT_RUN_FRAMES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic link_clk,
	input wire logic [7:0] ai_data,
	input wire logic ai_fs,
	output logic [7:0] ci_data,
	output logic ci_fs,
	input wire logic [7:0] ci_in_data,
	input wire logic ci_in_fs,
	output logic [7:0] ai_out_data,
	output logic ai_out_fs,
	input wire logic server_fail_in,
	input wire logic equipment_defect,
	output logic trail_fail_action,
	output logic trail_degraded_action
);
	import pot_pkg::*;

	// ----------------------------------------
	// pin synchronisers and link clock edge
	// ----------------------------------------
	pot_pins_t pin_s1;
	pot_pins_t pin_s2;
	logic clk_d;
	logic lk_edge;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			clk_d <= 1'b0;
		end
		else
		begin
			pin_s1 <= {link_clk, ai_fs, ai_data, ci_in_fs, ci_in_data,
				server_fail_in, equipment_defect};
			pin_s2 <= pin_s1;
			clk_d <= pin_s2.clk;
		end
	end

	// one byte per rising link clock edge
	assign lk_edge = pin_s2.clk & ~clk_d;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	pot_cfg_t cfg;
	pot_cfg_t next_cfg;
	pot_src_t src;
	pot_src_t next_src;
	pot_snk_t snk;
	pot_snk_t next_snk;
	logic wr_en;
	logic hit;
	logic [31:0] status_word;
	logic no_payload_cause;
	logic trace_mismatch_cause;
	logic error_rate_cause;
	logic far_fault_cause;
	logic server_fail_cause;
	logic alarm_fill_action;
	logic far_fault_request;
	logic far_error_request;

	// misaligned writes are flagged and must not land either
	assign wr_en = psel & penable & pwrite & (paddr[1:0] == 2'b00);
	assign pready = 1'b1;

	always_comb
	begin
		next_cfg = cfg;
		if (wr_en)
		begin
			case (paddr)
				`POT_REG_CTRL:
				begin
					next_cfg.trace_check_disable = pwdata[`POT_CTRL_TRACE_DIS];
					next_cfg.server_fail_report_enable =
						pwdata[`POT_CTRL_SSF_REP];
					next_cfg.far_fault_report_enable = pwdata[`POT_CTRL_FF_REP];
					next_cfg.fault_report_gate = pwdata[`POT_CTRL_GATE];
				end
				`POT_REG_DEGRADE:
				begin
					next_cfg.degrade_limit = pwdata[15:0];
					next_cfg.degrade_window_count = pwdata[19:16];
				end
				default:
				begin
					for (int j = 0; j < 4; j++)
					begin
						if (paddr[7:4] == 4'(`POT_REG_SENT >> 4))
							next_cfg.sent_trace_id[{paddr[3:2], 2'(j)}] =
								pwdata[8*j +: 8];
						if (paddr[7:4] == 4'(`POT_REG_EXPECT >> 4))
							next_cfg.expected_trace_id[{paddr[3:2], 2'(j)}] =
								pwdata[8*j +: 8];
					end
				end
			endcase
		end
	end

	always_comb
	begin
		status_word = '0;
		status_word[`POT_ST_UNEQ] = snk.no_payload_defect;
		status_word[`POT_ST_TIM] = snk.trace_mismatch_defect;
		status_word[`POT_ST_DEG] = snk.error_rate_defect;
		status_word[`POT_ST_FF] = snk.far_fault_defect;
		status_word[`POT_ST_C_UNEQ] = no_payload_cause;
		status_word[`POT_ST_C_TIM] = trace_mismatch_cause;
		status_word[`POT_ST_C_DEG] = error_rate_cause;
		status_word[`POT_ST_C_FF] = far_fault_cause;
		status_word[`POT_ST_C_SSF] = server_fail_cause;
		status_word[`POT_ST_NEAR_SEC] = snk.near_defect_second;
		status_word[`POT_ST_FAR_SEC] = snk.far_defect_second;
		status_word[`POT_ST_FILL] = alarm_fill_action;
		status_word[`POT_ST_TF] = snk.tf;
		status_word[`POT_ST_TD] = snk.td;
		hit = 1'b1;
		prdata = '0;
		case (paddr[7:4])
			4'(`POT_REG_SENT >> 4):
				prdata = cfg.sent_trace_id[{paddr[3:2], 2'b00} +: 4];
			4'(`POT_REG_EXPECT >> 4):
				prdata = cfg.expected_trace_id[{paddr[3:2], 2'b00} +: 4];
			4'(`POT_REG_ACCEPT >> 4):
				prdata = snk.accepted_trace_id[{paddr[3:2], 2'b00} +: 4];
			default:
			begin
				case (paddr)
					`POT_REG_CTRL:
						prdata = {28'h0000000, cfg.fault_report_gate,
							cfg.far_fault_report_enable,
							cfg.server_fail_report_enable,
							cfg.trace_check_disable};
					`POT_REG_DEGRADE:
						prdata = {12'h000, cfg.degrade_window_count,
							cfg.degrade_limit};
					`POT_REG_STATUS:
						prdata = status_word;
					`POT_REG_PERF:
						prdata = {snk.far_block_count, snk.near_block_count};
					default:
						hit = 1'b0;
				endcase
			end
		endcase
		if (paddr[1:0] != 2'b00)
			hit = 1'b0;
	end

	assign pslverr = psel & penable & ~hit;

	// ----------------------------------------
	// causes and actions
	// ----------------------------------------
	// fail actions
	assign far_fault_request = pin_s2.ssf | snk.no_payload_defect |
		snk.trace_mismatch_defect;
	assign alarm_fill_action = snk.no_payload_defect |
		snk.trace_mismatch_defect;
	assign far_error_request = snk.frame_err;
	assign no_payload_cause = cfg.fault_report_gate & snk.no_payload_defect;
	assign trace_mismatch_cause = cfg.fault_report_gate &
		snk.trace_mismatch_defect & ~snk.no_payload_defect;
	assign error_rate_cause = cfg.fault_report_gate & snk.error_rate_defect &
		~snk.no_payload_defect & ~snk.trace_mismatch_defect;
	assign far_fault_cause = cfg.fault_report_gate & snk.far_fault_defect &
		~snk.no_payload_defect & ~snk.trace_mismatch_defect &
		cfg.far_fault_report_enable;
	assign server_fail_cause = cfg.fault_report_gate & pin_s2.ssf &
		cfg.server_fail_report_enable;

	// ----------------------------------------
	// source: overhead insertion
	// ----------------------------------------
	always_comb
	begin
		next_src = src;
		if (lk_edge)
		begin
			// frame boundary restarts the byte position
			next_src.pos = pin_s2.ai_fs ? 12'h000 : src.pos + 12'h001;
			next_src.fs = pin_s2.ai_fs;
			// payload and other bits pass unchanged
			next_src.data = pin_s2.ai_data;
			case (next_src.pos)
				`POT_POS_SYNC_HI: next_src.data = SYNC_WORD[15:8];
				`POT_POS_SYNC_LO: next_src.data = SYNC_WORD[7:0];
				`POT_POS_TRACE:
				begin
					next_src.data = cfg.sent_trace_id[src.tidx];
					next_src.tidx = src.tidx + 4'h1;
				end
				// parity over the previous output frame
				`POT_POS_PARITY: next_src.data = src.last_par;
				`POT_POS_STATUS:
				begin
					next_src.data[`POT_MA_FAULT] = far_fault_request;
					next_src.data[`POT_MA_ERROR] = far_error_request;
				end
				default: next_src.data = pin_s2.ai_data;
			endcase
			if (pin_s2.ai_fs)
			begin
				next_src.last_par = src.par;
				next_src.par = next_src.data;
			end
			else
				next_src.par = src.par ^ next_src.data;
		end
	end

	assign ci_data = src.data;
	assign ci_fs = src.fs;

	// ----------------------------------------
	// sink: overhead check and defects
	// ----------------------------------------
	logic sec_pulse;
	logic [7:0] rxb;

	assign sec_pulse = snk.sec_cnt == 26'(SEC_CYCLES - 1);
	assign rxb = pin_s2.rx_data;

	always_comb
	begin
		next_snk = snk;
		next_snk.near_errored_block = 1'b0;
		next_snk.far_errored_block = 1'b0;
		if (lk_edge)
		begin
			next_snk.pos = pin_s2.rx_fs ? 12'h000 : snk.pos + 12'h001;
			next_snk.fs = pin_s2.rx_fs;
			// all ones while fill is requested
			next_snk.data = alarm_fill_action ? 8'hff : rxb;
			if (pin_s2.rx_fs)
			begin
				next_snk.last_par = snk.par;
				next_snk.par = rxb;
			end
			else
				next_snk.par = snk.par ^ rxb;
			case (next_snk.pos)
				// trace capture; msb marks the first byte
				`POT_POS_TRACE:
				begin
					next_snk.accepted_trace_id[rxb[7] ? 4'h0 : snk.tidx] = rxb;
					next_snk.tidx = (rxb[7] ? 4'h0 : snk.tidx) + 4'h1;
				end
				// parity check against the previous frame
				`POT_POS_PARITY:
				begin
					next_snk.near_errored_block = rxb != snk.last_par;
					next_snk.frame_err = rxb != snk.last_par;
				end
				`POT_POS_STATUS:
				begin
					next_snk.far_errored_block = rxb[`POT_MA_ERROR];
					// far fault defect over consecutive frames
					if (rxb[`POT_MA_FAULT] != snk.far_fault_defect)
						next_snk.fault_run = snk.fault_run + 3'h1;
					else
						next_snk.fault_run = 3'h0;
					if (next_snk.fault_run == 3'(RUN_FRAMES))
					begin
						next_snk.far_fault_defect = rxb[`POT_MA_FAULT];
						next_snk.fault_run = 3'h0;
					end
					if ((rxb[`POT_MA_LABEL_HI:`POT_MA_LABEL_LO] == 3'h0) !=
						snk.no_payload_defect)
						next_snk.label_run = snk.label_run + 3'h1;
					else
						next_snk.label_run = 3'h0;
					if (next_snk.label_run == 3'(RUN_FRAMES))
					begin
						next_snk.no_payload_defect = ~snk.no_payload_defect;
						next_snk.label_run = 3'h0;
					end
				end
				default: next_snk.frame_err = snk.frame_err;
			endcase
		end
		// mismatch, disableable and suppressed under server fail
		next_snk.trace_mismatch_defect = ~cfg.trace_check_disable &
			~pin_s2.ssf &
			(snk.accepted_trace_id != cfg.expected_trace_id);
		next_snk.tf = far_fault_request;
		next_snk.td = snk.error_rate_defect;
		next_snk.sec_cnt = sec_pulse ? 26'h0000000 : snk.sec_cnt + 26'h0000001;
		next_snk.near_acc = snk.near_acc + 16'(snk.near_errored_block);
		next_snk.far_acc = snk.far_acc + 16'(snk.far_errored_block);
		next_snk.near_acc_ds = snk.near_acc_ds | snk.tf | pin_s2.eqd;
		next_snk.far_acc_ds = snk.far_acc_ds | snk.far_fault_defect;
		if (sec_pulse)
		begin
			next_snk.near_block_count = next_snk.near_acc;
			next_snk.far_block_count = next_snk.far_acc;
			next_snk.near_defect_second = next_snk.near_acc_ds;
			next_snk.far_defect_second = next_snk.far_acc_ds;
			next_snk.near_acc = 16'h0000;
			next_snk.far_acc = 16'h0000;
			next_snk.near_acc_ds = 1'b0;
			next_snk.far_acc_ds = 1'b0;
			// degrade over a window of bad or good seconds
			if ((next_snk.near_block_count > cfg.degrade_limit) !=
				snk.error_rate_defect)
				next_snk.deg_run = snk.deg_run + 4'h1;
			else
				next_snk.deg_run = 4'h0;
			// window 0 acts as 1: a toggle needs an opposite second
			if ((next_snk.deg_run != 4'h0) &&
				(next_snk.deg_run >= cfg.degrade_window_count))
			begin
				next_snk.error_rate_defect = ~snk.error_rate_defect;
				next_snk.deg_run = 4'h0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg <= '0;
			cfg.degrade_limit <= `POT_DEG_LIMIT_RST;
			cfg.degrade_window_count <= `POT_DEG_WIN_RST;
			src <= '0;
			snk <= '0;
		end
		else
		begin
			cfg <= next_cfg;
			src <= next_src;
			snk <= next_snk;
		end
	end

	assign ai_out_data = snk.data;
	assign ai_out_fs = snk.fs;
	assign trail_fail_action = snk.tf;
	assign trail_degraded_action = snk.td;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic src_at_status;
	logic src_at_parity;
	assign src_at_status = lk_edge & ~pin_s2.ai_fs &
		(src.pos == `POT_POS_STATUS - 12'h001);
	assign src_at_parity = lk_edge & ~pin_s2.ai_fs &
		(src.pos == `POT_POS_PARITY - 12'h001);

	sequence fill_on;
		lk_edge && alarm_fill_action;
	endsequence

	chk_fill_all_ones: assert property (fill_on |=> ai_out_data == 8'hff)
		else $error("fill not all ones");
	chk_status_fault: assert property (src_at_status |=>
		ci_data[`POT_MA_FAULT] == $past(far_fault_request))
		else $error("status fault bit wrong");
	chk_status_error: assert property (src_at_status |=>
		ci_data[`POT_MA_ERROR] == $past(far_error_request))
		else $error("status error bit wrong");
	chk_parity_insert: assert property (src_at_parity |=>
		ci_data == $past(src.last_par))
		else $error("parity octet wrong");
	chk_sync_word: assert property ($rose(ci_fs) |->
		ci_data == SYNC_WORD[15:8])
		else $error("sync word missing");
	chk_trail_fail: assert property (far_fault_request |=>
		trail_fail_action ##1 trail_fail_action || !$past(far_fault_request))
		else $error("trail fail not raised");
	chk_cause_gate: assert property (!cfg.fault_report_gate |->
		!(no_payload_cause | trace_mismatch_cause | far_fault_cause))
		else $error("cause without gate");
	chk_degrade_mask: assert property (error_rate_cause |->
		!snk.no_payload_defect && !snk.trace_mismatch_defect)
		else $error("degrade cause not masked");
	chk_second_count: assert property (sec_pulse |=>
		snk.near_block_count == $past(snk.near_acc) +
		16'($past(snk.near_errored_block)) && snk.near_acc == 16'h0000)
		else $error("second count wrong");

endmodule

`default_nettype wire

// ### testbench/pot_far_model.sv
// far side model: adaptation source and a line loopback for the sink
`timescale 1ns/1ps
`default_nettype none

module pot_far_model
(
	output logic link_clk,
	output logic [7:0] ai_data,
	output logic ai_fs,
	input wire logic [7:0] ci_data,
	input wire logic ci_fs,
	output logic [7:0] ci_in_data,
	output logic ci_in_fs,
	input wire logic corrupt
);
	// ----------------------------------------
	// short frames keep the run brief; fs resyncs the block
	// ----------------------------------------
	localparam int FLEN = 16;
	logic [7:0] pos;
	logic [7:0] cap_d;
	logic cap_fs;

	initial
	begin
		link_clk = 1'b0;
		pos = 8'h00;
		ai_data = 8'h00;
		ai_fs = 1'b0;
		ci_in_data = 8'h00;
		ci_in_fs = 1'b0;
		cap_d = 8'h00;
		cap_fs = 1'b0;
	end

	// data clock of the carried signal runs continuously
	always #80 link_clk = ~link_clk;

	always @(negedge link_clk)
	begin
		ai_fs <= (pos == 8'h00);
		ai_data <= (pos == 8'h04) ? 8'h20 : (pos ^ 8'h5a);
		pos <= (pos == 8'(FLEN - 1)) ? 8'h00 : pos + 8'h01;
		// a set corrupt flips bit 0 of each looped byte while it stays set
		ci_in_data <= cap_d ^ {7'h00, corrupt};
		ci_in_fs <= cap_fs;
	end

	// sample on the rising edge, where the source output is settled
	always @(posedge link_clk)
	begin
		cap_d <= ci_data;
		cap_fs <= ci_fs;
	end
endmodule

`default_nettype wire

// ### testbench/tb_path_overhead_termination.sv
// self-checking testbench of the path overhead termination block
`timescale 1ns/1ps
`default_nettype none
`include "pot_consts.svh"

module tb_path_overhead_termination;
	localparam logic [15:0] SYNC = 16'hc3a5;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, ai_data, ci_data, ci_in_data, ai_out_data;
	logic [31:0] pwdata, prdata, rd;
	logic link_clk, ai_fs, ci_fs, ci_in_fs, ai_out_fs, err, corrupt;
	logic server_fail_in, equipment_defect;
	logic trail_fail_action, trail_degraded_action;
	logic [7:0] frm [4][16];
	int n_fail, checks;

	pot_top #(.SEC_CYCLES(2000), .SYNC_WORD(SYNC)) dut
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .link_clk, .ai_data, .ai_fs,
		.ci_data, .ci_fs, .ci_in_data, .ci_in_fs, .ai_out_data,
		.ai_out_fs, .server_fail_in, .equipment_defect,
		.trail_fail_action, .trail_degraded_action
	);

	pot_far_model far
	(
		.link_clk, .ai_data, .ai_fs, .ci_data, .ci_fs, .ci_in_data,
		.ci_in_fs, .corrupt
	);

	always #10 pclk = ~pclk;

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic hang();
		n_fail++;
		$display("MISMATCH %0t: wait ran out", $time);
		close_out();
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 50)
			hang();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// consecutive calls catch consecutive frames of the source output
	task automatic get_frames(input int n);
		int i;
		for (int f = 0; f < n; f++)
		begin
			for (i = 0; i < 40; i++)
			begin
				@(posedge link_clk);
				if (ci_fs === 1'b1)
					break;
			end
			if (i == 40)
				hang();
			frm[f][0] = ci_data;
			for (int b = 1; b < 16; b++)
			begin
				@(posedge link_clk);
				frm[f][b] = ci_data;
			end
		end
	endtask

	task automatic wait_tf(input logic v);
		int i;
		for (i = 0; i < 400 && trail_fail_action !== v; i++)
			@(posedge pclk);
		if (i == 400)
			hang();
	endtask

	// trace byte 0 carries the start marker in bit 7
	function automatic logic [7:0] tbyte(input int i);
		return (i == 0) ? 8'h80 : (8'h40 | i[7:0]);
	endfunction

	function automatic logic [31:0] tword(input int k);
		return {tbyte(4*k+3), tbyte(4*k+2), tbyte(4*k+1), tbyte(4*k)};
	endfunction

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		apb(1'b0, `POT_REG_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, `POT_REG_DEGRADE, 32'h0);
		chk(rd, 32'h0002_0000);
		apb(1'b0, 8'h44, 32'h0);
		chk({31'h0, err}, 32'h1);
		// check stays off until the accepted trace is complete
		apb(1'b1, `POT_REG_CTRL, 32'h9);
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b1, `POT_REG_SENT + 8'(4*k), tword(k));
			apb(1'b1, `POT_REG_EXPECT + 8'(4*k), tword(k));
		end
		apb(1'b0, `POT_REG_CTRL, 32'h0);
		chk(rd, 32'h9);
		// a misaligned write is flagged and must not land
		apb(1'b1, `POT_REG_SENT + 8'h01, 32'hffff_ffff);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, `POT_REG_SENT, 32'h0);
		chk(rd, tword(0));
		apb(1'b0, `POT_REG_SENT + 8'h0c, 32'h0);
		chk(rd, tword(3));
	endtask

	task automatic t_source();
		logic [7:0] p;
		get_frames(4);
		chk(frm[2][0], SYNC[15:8]);
		chk(frm[2][1], SYNC[7:0]);
		chk(frm[2][4], 8'h20);
		chk(frm[2][5], 8'h5f);
		for (int b = 6; b < 16; b++)
			chk(frm[2][b], 8'(b) ^ 8'h5a);
		p = 8'h00;
		for (int b = 0; b < 16; b++)
			p = p ^ frm[2][b];
		chk(frm[3][3], p);
		for (int f = 0; f < 17 && frm[0][2] !== 8'h80; f++)
			get_frames(1);
		chk(frm[0][2], 8'h80);
		for (int k = 1; k < 16; k++)
		begin
			get_frames(1);
			chk(frm[0][2], tbyte(k));
		end
		get_frames(2);
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b0, `POT_REG_ACCEPT + 8'(4*k), 32'h0);
			chk(rd, tword(k));
		end
	endtask

	task automatic t_mismatch();
		apb(1'b1, `POT_REG_EXPECT, 32'h0);
		apb(1'b1, `POT_REG_CTRL, 32'h8);
		wait_tf(1'b1);
		repeat (3) @(posedge link_clk);
		chk(ai_out_data, 8'hff);
		get_frames(2);
		chk(frm[1][4][7], 1'b1);
		apb(1'b0, `POT_REG_STATUS, 32'h0);
		chk(rd & 32'h18a3, 32'h1822);
		apb(1'b1, `POT_REG_CTRL, 32'h9);
		wait_tf(1'b0);
		get_frames(2);
		chk(frm[1][4][7], 1'b0);
		apb(1'b0, `POT_REG_STATUS, 32'h0);
		chk(rd[11], 1'b0);
		apb(1'b1, `POT_REG_EXPECT, tword(0));
		apb(1'b1, `POT_REG_CTRL, 32'h8);
	endtask

	task automatic t_server();
		@(posedge pclk);
		server_fail_in <= 1'b1;
		wait_tf(1'b1);
		apb(1'b0, `POT_REG_STATUS, 32'h0);
		chk(rd[8], 1'b0);
		apb(1'b1, `POT_REG_CTRL, 32'ha);
		apb(1'b0, `POT_REG_STATUS, 32'h0);
		chk(rd[8], 1'b1);
		@(posedge pclk);
		server_fail_in <= 1'b0;
		wait_tf(1'b0);
		apb(1'b1, `POT_REG_CTRL, 32'h8);
	endtask

	task automatic t_parity();
		logic [2:0] n;
		logic near_one, far_one, eq_one, deg_any;
		int i;
		n = 3'h0;
		near_one = 1'b0;
		far_one = 1'b0;
		eq_one = 1'b0;
		deg_any = 1'b0;
		@(posedge pclk);
		equipment_defect <= 1'b1;
		// align to a frame so that payload byte 8 is the one flipped;
		// a flipped trace or parity octet would give other counts
		for (i = 0; i < 40; i++)
		begin
			@(posedge link_clk);
			if (ci_fs === 1'b1)
				break;
		end
		if (i == 40)
			hang();
		repeat (8) @(posedge link_clk);
		corrupt <= 1'b1;
		@(posedge link_clk);
		corrupt <= 1'b0;
		get_frames(4);
		for (int f = 0; f < 4; f++)
			n = n + {2'h0, frm[f][4][6]};
		chk(n, 3'h1);
		// one error must show once in each count, spanning a few seconds
		for (int k = 0; k < 60; k++)
		begin
			apb(1'b0, `POT_REG_PERF, 32'h0);
			near_one = near_one | (rd[15:0] === 16'h0001);
			far_one = far_one | (rd[31:16] === 16'h0001);
			apb(1'b0, `POT_REG_STATUS, 32'h0);
			eq_one = eq_one | (rd[9] === 1'b1);
			deg_any = deg_any | (trail_degraded_action !== 1'b0);
			repeat (80) @(posedge pclk);
		end
		chk(near_one, 1'b1);
		chk(far_one, 1'b1);
		chk(eq_one, 1'b1);
		// a single bad second is below the window of two
		chk(deg_any, 1'b0);
		@(posedge pclk);
		equipment_defect <= 1'b0;
	endtask

	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		server_fail_in = 1'b0;
		equipment_defect = 1'b0;
		corrupt = 1'b0;
		n_fail = 0;
		checks = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_source();
		t_mismatch();
		t_server();
		t_parity();
		close_out();
	end
endmodule

`default_nettype wire
